//--- wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ------------------------------------------------------------
// Register offsets (indices on the plain register port)
// ------------------------------------------------------------
`define WDT_OFF_CONFIG 2'h0
`define WDT_OFF_KEYFLAGS 2'h1
`define WDT_OFF_SNAPSHOT 2'h2
`define WDT_OFF_CONTROL 2'h3

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define WDT_CFG_WS_HI 7
`define WDT_CFG_WS_LO 5
`define WDT_CFG_RCEN_HI 3
`define WDT_CFG_RCEN_LO 2
`define WDT_CFG_PWR_HI 1
`define WDT_CFG_PWR_LO 0
`define WDT_KEY_HI 7
`define WDT_KEY_LO 3
`define WDT_BIT_BOR 2
`define WDT_BIT_BSR 1
`define WDT_BIT_KRF 0
`define WDT_CTL_PDF 1
`define WDT_CTL_TO 0

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define WDT_CFG_RESET 8'hE9
`define WDT_KEY_ENABLE 5'h0A
`define WDT_KEY_ALT 5'h15
`define WDT_RCEN_OFF 2'h1
`define WDT_PWR_REG 2'h2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define WDT_INSTR_DIV 4
`define WDT_KEY_RST_DELAY 2
`define WDT_CNT_W 16

`endif

//--- wdt_pkg.sv
package wdt_pkg;

    // Watchdog clock source
    typedef enum logic [1:0]
    {
        SRC_SLOW_RC = 2'b00,
        SRC_SLOW_XTAL = 2'b01,
        SRC_INSTR = 2'b10
    } clk_src_e;

    // Key-reset sequencer state
    typedef enum logic [1:0]
    {
        KEY_IDLE = 2'b00,
        KEY_WAIT = 2'b01,
        KEY_FIRE = 2'b10
    } key_state_e;

endpackage : wdt_pkg

//--- wdt_tick_gen.sv
`timescale 1ns/10ps
`include "wdt_defs.svh"

// Makes one-cycle count ticks from the selected watchdog clock source
module wdt_tick_gen
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [1:0] src_sel,
    input wire logic slow_rc_run,
    input wire logic powerdown,
    input wire logic slow_rc_edge,
    input wire logic slow_xtal_edge,
    output logic tick,
    output logic rc_tick
);

    logic [1:0] div_r; // Instruction clock divider

    // ------------------------------------------------------------
    // Instruction clock: system clock divided by four
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            div_r <= 2'h0;
        else if (clk_en)
            div_r <= div_r + 2'h1;
    end

    // Stopped slow RC gives no edges at all, whoever selects it
    assign rc_tick = slow_rc_edge & slow_rc_run;

    // Source mux; instruction clock dies with the system clock in power-down
    always_comb
    begin
        unique case (src_sel)
            2'b00: tick = rc_tick;
            2'b01: tick = slow_xtal_edge;
            2'b10: tick = (div_r == 2'h3) & ~powerdown;
            default: tick = 1'b0;
        endcase
    end

endmodule : wdt_tick_gen

//--- wdt_core.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "wdt_defs.svh"

// Behaviour
// - Watchdog clocks from slow RC, crystal, instruction
// - Always-on: both valid keys keep it enabled
// - Software mode: 10101 disables, 01010 enables
// - Bad key resets after two-three slow RC cycles; here on the second edge, after one to two cycles
// - Bad key sets key-reset flag
// - Timeout period is two to eight-plus-field
// - Disabled watchdog never resets; counter readable, clearable; here a bad-key reset already pending still fires
// - Snapshot returns counter bits four to eleven
// - Slow RC off only at enable field 01
// - Disabled slow RC stops for everyone
// - Regulator supply only at field 10
// - Instruction clock stops counting in power-down
// - Normal overflow: full reset, set expiry flag
// - Power-down overflow: warm reset only
// - Counter cleared by pin, clear instruction, halt
// - Single clear or clear pair, by option
// - Brownout flags hardware-set, software-cleared only
// - Key field powers up as 01010
// - Halt clears counter, restarts on slow clocks
// - Halt sets powerdown flag, clears expiry flag; here an enabled overflow in the same cycle keeps it set
module wdt_core
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [1:0] src_sel,
    input wire logic always_on,
    input wire logic clear_pair_mode,
    input wire logic slow_rc_edge,
    input wire logic slow_xtal_edge,
    input wire logic external_reset_pin_n,
    input wire logic single_clear_instr,
    input wire logic pair_clear_first,
    input wire logic pair_clear_second,
    input wire logic halt_instr,
    input wire logic wake_event,
    input wire logic brownout_reset,
    input wire logic brownout_setting_reset,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic device_reset,
    output logic warm_reset,
    output logic slow_rc_on,
    output logic regulator_supply
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [2:0] timeout_select_r; // Period select
    logic [1:0] slow_rc_enable_field_r; // Slow RC enable
    logic [1:0] slow_rc_power_select_r; // Supply select
    logic [4:0] watchdog_key_field_r; // Key field
    logic brownout_reset_flag_r; // Brownout cause
    logic brownout_setting_reset_flag_r; // Brownout-setting cause
    logic key_reset_flag_r; // Bad-key cause
    logic expiry_flag_r; // Time-out cause
    logic powerdown_flag_r; // Halt entered
    logic powerdown_r; // In power-down
    logic [`WDT_CNT_W-1:0] count_r; // Watchdog counter
    logic pair_first_seen_r; // First half of pair done
    logic pair_second_seen_r; // Second half of pair done
    logic [1:0] key_wait_r; // Slow RC edges since bad key
    wdt_pkg::key_state_e key_state_r; // Key-reset sequencer
    logic pin_sync1_r; // Reset pin, first stage
    logic pin_sync2_r; // Reset pin, second stage
    logic rc_sync1_r; // Slow RC edge, first stage
    logic rc_sync2_r; // Slow RC edge, second stage
    logic xt_sync1_r; // Crystal edge, first stage
    logic xt_sync2_r; // Crystal edge, second stage
    logic device_reset_r; // Full reset pulse
    logic warm_reset_r; // Warm reset pulse
    logic [7:0] reg_rdata_r; // Read data

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    logic tick; // One count step
    logic rc_tick; // Running slow RC edge
    logic enabled; // Watchdog may reset
    logic key_write; // Key register written
    logic [4:0] key_new; // Written key
    logic key_bad; // Written key is illegal
    logic sw_clear; // Software clear this cycle
    logic overflow; // Selected bit reached
    logic [3:0] ovf_bit; // Overflow bit index
    logic snap_wr; // Counter register written

    assign key_write = reg_wr & (reg_addr == `WDT_OFF_KEYFLAGS);
    assign key_new = reg_wdata[`WDT_KEY_HI:`WDT_KEY_LO];
    assign key_bad = (key_new != `WDT_KEY_ENABLE) && (key_new != `WDT_KEY_ALT);
    assign snap_wr = reg_wr & (reg_addr == `WDT_OFF_SNAPSHOT);

    // Always-on ignores the disable code; software mode honours it
    assign enabled = always_on | (watchdog_key_field_r != `WDT_KEY_ALT);

    // With the pair option a lone half clears nothing
    assign sw_clear = clear_pair_mode ?
        ((pair_first_seen_r | pair_clear_first) & (pair_second_seen_r | pair_clear_second)) :
        single_clear_instr;

    // Period is 2^(8+select) watchdog clocks
    assign ovf_bit = 4'h8 + {1'b0, timeout_select_r};
    assign overflow = tick & (count_r[ovf_bit[3:0] - 4'h1 -: 1] == 1'b1)
        & (count_r[ovf_bit - 4'h1] == 1'b1) & (&(count_r | ~((16'h1 << ovf_bit) - 16'h1)));

    // ------------------------------------------------------------
    // Tick generator
    // ------------------------------------------------------------
    wdt_tick_gen u_tick
    (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .src_sel(src_sel),
        .slow_rc_run(slow_rc_on),
        .powerdown(powerdown_r),
        .slow_rc_edge(rc_sync2_r),
        .slow_xtal_edge(xt_sync2_r),
        .tick(tick),
        .rc_tick(rc_tick)
    );

    // ------------------------------------------------------------
    // Synchronisers for pins; only stage two is read
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_sync1_r <= 1'b1;
            pin_sync2_r <= 1'b1;
            rc_sync1_r <= 1'b0;
            rc_sync2_r <= 1'b0;
            xt_sync1_r <= 1'b0;
            xt_sync2_r <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_sync1_r <= external_reset_pin_n;
            pin_sync2_r <= pin_sync1_r;
            rc_sync1_r <= slow_rc_edge;
            rc_sync2_r <= rc_sync1_r;
            xt_sync1_r <= slow_xtal_edge;
            xt_sync2_r <= xt_sync1_r;
        end
    end

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            timeout_select_r <= 3'(`WDT_CFG_RESET >> `WDT_CFG_WS_LO);
            slow_rc_enable_field_r <= 2'(`WDT_CFG_RESET >> `WDT_CFG_RCEN_LO);
            slow_rc_power_select_r <= 2'(`WDT_CFG_RESET >> `WDT_CFG_PWR_LO);
        end
        else if (clk_en && reg_wr && reg_addr == `WDT_OFF_CONFIG)
        begin
            timeout_select_r <= reg_wdata[`WDT_CFG_WS_HI:`WDT_CFG_WS_LO];
            slow_rc_enable_field_r <= reg_wdata[`WDT_CFG_RCEN_HI:`WDT_CFG_RCEN_LO];
            slow_rc_power_select_r <= reg_wdata[`WDT_CFG_PWR_HI:`WDT_CFG_PWR_LO];
        end
    end

    // Oscillator control outputs, registered
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            slow_rc_on <= 1'b1;
            regulator_supply <= 1'b0;
        end
        else if (clk_en)
        begin
            slow_rc_on <= (slow_rc_enable_field_r != `WDT_RCEN_OFF);
            regulator_supply <= (slow_rc_power_select_r == `WDT_PWR_REG);
        end
    end

    // ------------------------------------------------------------
    // Key field; powers up enabled
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            watchdog_key_field_r <= `WDT_KEY_ENABLE;
        else if (clk_en && key_write)
            watchdog_key_field_r <= key_new;
    end

    // ------------------------------------------------------------
    // Key-reset sequencer: waits two slow RC edges, fires the cycle after the second
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            key_state_r <= wdt_pkg::KEY_IDLE;
            key_wait_r <= 2'h0;
        end
        else if (clk_en)
        begin
            unique case (key_state_r)
                wdt_pkg::KEY_IDLE:
                begin
                    key_wait_r <= 2'h0;
                    if (key_write && key_bad)
                        key_state_r <= wdt_pkg::KEY_WAIT;
                end
                wdt_pkg::KEY_WAIT:
                begin
                    // Partial first RC period gives the one-to-two period spread
                    if (rc_tick)
                        key_wait_r <= key_wait_r + 2'h1;
                    if (rc_tick && key_wait_r == 2'(`WDT_KEY_RST_DELAY - 1))
                        key_state_r <= wdt_pkg::KEY_FIRE;
                end
                wdt_pkg::KEY_FIRE:
                    key_state_r <= wdt_pkg::KEY_IDLE;
                default:
                    key_state_r <= wdt_pkg::KEY_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Reset-cause flags; hardware set wins over software clear
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            brownout_reset_flag_r <= 1'b0;
            brownout_setting_reset_flag_r <= 1'b0;
            key_reset_flag_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // Software may only write zero to these
            if (brownout_reset)
                brownout_reset_flag_r <= 1'b1;
            else if (key_write && !reg_wdata[`WDT_BIT_BOR])
                brownout_reset_flag_r <= 1'b0;
            if (brownout_setting_reset)
                brownout_setting_reset_flag_r <= 1'b1;
            else if (key_write && !reg_wdata[`WDT_BIT_BSR])
                brownout_setting_reset_flag_r <= 1'b0;
            if (key_state_r == wdt_pkg::KEY_FIRE)
                key_reset_flag_r <= 1'b1;
            else if (key_write && !reg_wdata[`WDT_BIT_KRF])
                key_reset_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Power-down state and status flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            powerdown_r <= 1'b0;
            powerdown_flag_r <= 1'b0;
            expiry_flag_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (halt_instr)
            begin
                powerdown_r <= 1'b1;
                powerdown_flag_r <= 1'b1;
                expiry_flag_r <= overflow && enabled; // Same-cycle expiry wins
            end
            else
            begin
                if (wake_event || (overflow && enabled))
                    powerdown_r <= 1'b0;
                if (overflow && enabled)
                    expiry_flag_r <= 1'b1;
                if (sw_clear)
                    powerdown_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Clear-pair tracking
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pair_first_seen_r <= 1'b0;
            pair_second_seen_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (sw_clear || !clear_pair_mode)
            begin
                pair_first_seen_r <= 1'b0;
                pair_second_seen_r <= 1'b0;
            end
            else
            begin
                if (pair_clear_first)
                    pair_first_seen_r <= 1'b1;
                if (pair_clear_second)
                    pair_second_seen_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            count_r <= '0;
        else if (clk_en)
        begin
            // Halt clears; instruction source then stalls anyway
            if (!pin_sync2_r || sw_clear || halt_instr)
                count_r <= '0;
            else if (snap_wr && !enabled)
                count_r <= '0;
            else if (overflow)
                count_r <= '0;
            else if (tick)
                count_r <= count_r + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // Reset outputs: one-cycle pulses
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            device_reset_r <= 1'b0;
            warm_reset_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // A disabled watchdog never resets the chip on overflow; a pending bad-key reset still fires
            device_reset_r <= (overflow && enabled && !powerdown_r)
                || key_state_r == wdt_pkg::KEY_FIRE;
            warm_reset_r <= overflow && enabled && powerdown_r;
        end
    end

    assign device_reset = device_reset_r;
    assign warm_reset = warm_reset_r;

    // ------------------------------------------------------------
    // Register read port, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            reg_rdata_r <= 8'h00;
        else if (clk_en)
        begin
            if (!reg_rd)
                reg_rdata_r <= 8'h00;
            else
            begin
                unique case (reg_addr)
                    `WDT_OFF_CONFIG:
                        reg_rdata_r <= {timeout_select_r, 1'b0, slow_rc_enable_field_r, slow_rc_power_select_r};
                    `WDT_OFF_KEYFLAGS:
                        reg_rdata_r <= {watchdog_key_field_r, brownout_reset_flag_r,
                            brownout_setting_reset_flag_r, key_reset_flag_r};
                    `WDT_OFF_SNAPSHOT:
                        reg_rdata_r <= count_r[11:4];
                    `WDT_OFF_CONTROL:
                        reg_rdata_r <= {6'h00, powerdown_flag_r, expiry_flag_r};
                endcase
            end
        end
    end

    assign reg_rdata = reg_rdata_r;

endmodule : wdt_core

//--- wdt_core_monitor.sv
`timescale 1ns/10ps

// Watches the register port and the reset and supply outputs of the core
module wdt_core_monitor
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic device_reset,
    input wire logic warm_reset,
    input wire logic slow_rc_on,
    input wire logic regulator_supply
);
    // ------
    // Shadow of the config register
    // ------
    logic [7:0] cfg_r; // Last value written to config
    logic cfg_wr; // Config write taken at this edge

    assign cfg_wr = reg_wr && clk_en && reg_addr == 2'h0;

    // Follows config writes so outputs can be tied back to their cause
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cfg_r <= 8'hE9;
        end
        else if (cfg_wr)
        begin
            cfg_r <= reg_wdata;
        end
    end

    // ------
    // Properties
    // ------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Read data must be zero outside its one answer cycle
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside answer cycle");

    // Config reads back what was written, unused bit as zero
    cfg_read_a: assert property (
        reg_rd && reg_addr == 2'h0 |=> reg_rdata == (cfg_r & 8'hEF))
        else $error("config read mismatch");

    // Two quiet edges let the registered output settle
    rc_enable_a: assert property (
        !cfg_wr [*2] |-> slow_rc_on == (cfg_r[3:2] != 2'h1))
        else $error("slow rc enable does not follow field");

    supply_sel_a: assert property (
        !cfg_wr [*2] |-> regulator_supply == (cfg_r[1:0] == 2'h2))
        else $error("supply select does not follow field");

    // Two synchronised slow ticks cannot arrive within four edges
    badkey_delay_a: assert property (
        reg_wr && reg_addr == 2'h1 && reg_wdata[7:3] != 5'h0A && reg_wdata[7:3] != 5'h15
        |=> !device_reset [*4])
        else $error("key reset came too early");

    dev_pulse_a: assert property (
        device_reset |=> !device_reset)
        else $error("full reset longer than one cycle");

    warm_pulse_a: assert property (
        warm_reset |=> !warm_reset)
        else $error("warm reset longer than one cycle");

    reset_excl_a: assert property (
        !(device_reset && warm_reset))
        else $error("warm and full reset together");
endmodule : wdt_core_monitor

//--- tb.sv
`timescale 1ns/10ps

// Self-checking bench for the watchdog core
module tb;
    // ------
    // Stimulus and observation
    // ------
    logic core_clk, reset, clk_en, always_on, clear_pair_mode;
    logic external_reset_pin_n, reg_wr, reg_rd;
    logic [1:0] src_sel, reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [8:0] ev; // One-cycle events: edges, clears, halt, wake, brownouts
    logic device_reset, warm_reset, slow_rc_on, regulator_supply;
    int err_count = 0;
    int checks = 0;
    int dev_cnt = 0; // Full resets seen
    int warm_cnt = 0; // Warm resets seen

    wdt_core dut
    (
        .core_clk, .reset, .clk_en, .src_sel, .always_on, .clear_pair_mode,
        .slow_rc_edge(ev[0]), .slow_xtal_edge(ev[1]), .external_reset_pin_n,
        .single_clear_instr(ev[2]), .pair_clear_first(ev[3]), .pair_clear_second(ev[4]),
        .halt_instr(ev[5]), .wake_event(ev[6]), .brownout_reset(ev[7]),
        .brownout_setting_reset(ev[8]), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .device_reset, .warm_reset, .slow_rc_on, .regulator_supply
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Non-blocking counts so a check at the same edge sees a stable value
    always @(posedge core_clk)
    begin
        if (device_reset === 1'b1) dev_cnt <= dev_cnt + 1;
        if (warm_reset === 1'b1) warm_cnt <= warm_cnt + 1;
    end

    // ------
    // Tasks
    // ------
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmpc(input int got, input int exp);
        checks++;
        if (got != exp)
        begin
            err_count++;
            $display("BAD %0t reset count %0d expected %0d", $time, got, exp);
        end
    endtask : cmpc

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        cmp8(reg_rdata, e);
    endtask : rd

    task pls(input int i);
        ev[i] <= 1'b1;
        @(posedge core_clk);
        ev[i] <= 1'b0;
    endtask : pls

    // Slow clock edges spaced four cycles apart, above the sync limit
    task automatic tick(input int n, input logic [1:0] m);
        repeat (n)
        begin
            ev[1:0] <= m;
            @(posedge core_clk);
            ev[1:0] <= 2'h0;
            repeat (3) @(posedge core_clk);
        end
    endtask : tick

    // Nothing before the last tick, then the expected reset kinds
    task automatic expire(input int n, input logic [1:0] m, input int dw, input int ww);
        int d;
        int w;
        d = dev_cnt;
        w = warm_cnt;
        tick(n - 1, m);
        repeat (6) @(posedge core_clk);
        cmpc(dev_cnt + warm_cnt, d + w);
        tick(1, m);
        repeat (6) @(posedge core_clk);
        cmpc(dev_cnt, d + dw);
        cmpc(warm_cnt, w + ww);
    endtask : expire

    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // ------
    // Main sequence
    // ------
    initial
    begin
        int d;
        reset = 1'b1;
        clk_en = 1'b1;
        src_sel = 2'h0;
        always_on = 1'b1;
        clear_pair_mode = 1'b0;
        external_reset_pin_n = 1'b1;
        ev = 9'h000;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(2'h0, 8'hE9);
        rd(2'h1, 8'h50);
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        // Flags cannot be set by software, only by events
        wr(2'h1, 8'h56);
        rd(2'h1, 8'h50);
        pls(7);
        pls(8);
        rd(2'h1, 8'h56);
        wr(2'h1, 8'h50);
        rd(2'h1, 8'h50);
        // Every enable and supply code
        for (int i = 0; i < 4; i++)
        begin
            wr(2'h0, {4'h0, i[1:0], i[1:0]});
            repeat (2) @(posedge core_clk);
            cmp8({7'h0, slow_rc_on}, {7'h0, i != 1});
            cmp8({7'h0, regulator_supply}, {7'h0, i == 2});
        end
        // A stopped slow RC must not count
        wr(2'h0, 8'h05);
        pls(2);
        tick(40, 2'h1);
        rd(2'h2, 8'h00);
        wr(2'h0, 8'h09);
        tick(32, 2'h1);
        rd(2'h2, 8'h02);
        clear_pair_mode <= 1'b1;
        pls(3);
        rd(2'h2, 8'h02);
        pls(2);
        rd(2'h2, 8'h02);
        pls(4);
        rd(2'h2, 8'h00);
        clear_pair_mode <= 1'b0;
        tick(32, 2'h1);
        external_reset_pin_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        external_reset_pin_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(2'h2, 8'h00);
        pls(2);
        expire(256, 2'h1, 1, 0);
        rd(2'h3, 8'h01);
        wr(2'h0, 8'h29);
        expire(512, 2'h1, 1, 0);
        wr(2'h0, 8'h09);
        src_sel <= 2'h1;
        pls(2);
        expire(256, 2'h2, 1, 0);
        src_sel <= 2'h0;
        pls(2);
        tick(32, 2'h1);
        pls(5);
        rd(2'h3, 8'h02);
        rd(2'h2, 8'h00);
        expire(256, 2'h1, 0, 1);
        pls(6);
        // Instruction clock is the core clock divided by four
        src_sel <= 2'h2;
        pls(2);
        d = dev_cnt;
        repeat (1000) @(posedge core_clk);
        cmpc(dev_cnt, d);
        repeat (60) @(posedge core_clk);
        cmpc(dev_cnt, d + 1);
        pls(5);
        d = dev_cnt + warm_cnt;
        repeat (1100) @(posedge core_clk);
        cmpc(dev_cnt + warm_cnt, d);
        pls(6);
        src_sel <= 2'h0;
        always_on <= 1'b0;
        wr(2'h1, 8'hA8);
        expire(300, 2'h1, 0, 0);
        wr(2'h2, 8'hFF);
        rd(2'h2, 8'h00);
        // Clock enable low freezes the counter against slow RC edges
        clk_en <= 1'b0;
        tick(20, 2'h1);
        clk_en <= 1'b1;
        rd(2'h2, 8'h00);
        wr(2'h1, 8'h50);
        expire(256, 2'h1, 1, 0);
        always_on <= 1'b1;
        wr(2'h1, 8'hA8);
        pls(2);
        expire(256, 2'h1, 1, 0);
        // Bad key: reset only after the second slow RC tick
        pls(2);
        wr(2'h1, 8'h00);
        d = dev_cnt;
        tick(1, 2'h1);
        repeat (3) @(posedge core_clk);
        cmpc(dev_cnt, d);
        tick(1, 2'h1);
        repeat (3) @(posedge core_clk);
        cmpc(dev_cnt, d + 1);
        wr(2'h1, 8'h51);
        rd(2'h1, 8'h51);
        report_and_stop();
    end

    // Tests need about 11000 cycles; this bounds a hang
    initial
    begin
        #600000;
        err_count++;
        report_and_stop();
    end
endmodule : tb

bind wdt_core wdt_core_monitor mon
(
    .core_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .device_reset, .warm_reset, .slow_rc_on, .regulator_supply
);
